// ---- hdl/secl_loader.v ----
`timescale 1ns/1ps
`default_nettype none
`include "secl_defs.vh"
module secl_loader #(
	parameter HALF_CYC = `SECL_SCL_HALF_NS / `SECL_CLK_NS
) (
	input  wire        clk_sys,
	input  wire        arst_n,
	output wire        scl_o,
	output wire        scl_oe,
	input  wire        sda_i,
	output wire        sda_o,
	output wire        sda_oe,
	input  wire        tgt_req,
	input  wire        tgt_wr,
	input  wire [7:0]  tgt_addr,
	input  wire [31:0] tgt_wdata,
	output wire        tgt_retry,
	output wire        tgt_ack,
	output reg  [31:0] tgt_rdata,
	output wire        loading,
	output wire        prio_arb_enable,
	output wire        phy_accel_support,
	output wire        phy_program_permit
);
	// sequencer states, one per part of the random read
	localparam S_START  = 3'd0;
	localparam S_BIT    = 3'd1;
	localparam S_ACK    = 3'd2;
	localparam S_RSTART = 3'd3;
	localparam S_READ   = 3'd4;
	localparam S_MACK   = 3'd5;
	localparam S_STOP   = 3'd6;
	localparam S_DONE   = 3'd7;

	// two-wire sequencer
	reg [2:0]  st_r;
	reg [1:0]  phase_r;   // 0 low,1 rise,2 high,3 fall
	reg [15:0] div_r;
	reg [3:0]  bitn_r;
	reg [8:0]  sh_r;
	reg [1:0]  cmd_r;     // 0 dev wr,1 word addr,2 dev rd
	reg [4:0]  idx_r;
	reg        scl_r;
	reg        sda_r;
	// pin synchroniser flops
	reg        sda_m_r;
	reg        sda_s_r;
	// loaded configuration
	reg [15:0] latgnt_r;
	reg [15:0] vend_r;
	reg [15:0] subsys_r;
	reg [31:0] guid_hi_r;
	reg [31:0] guid_lo_r;
	reg        prio_r;
	reg        accel_r;
	reg        phyperm_r;
	reg        dis_pipe_r;
	reg [1:0]  atx_r;
	// read byte under assembly, msb first
	reg [7:0]  byte_r;
	wire       tick;
	wire [31:0] link_enh;
	wire [31:0] hc_ctrl;
	// target side decodes gated off while loading; ee_commit fires only during the load
	wire        wr_link;
	wire        wr_hc;
	wire        rd_take;
	wire        ee_commit;

	assign tick = (div_r == 16'h0000);
	// open drain: drive only low
	assign scl_o  = 1'b0;
	assign scl_oe = ~scl_r;
	assign sda_o  = 1'b0;
	assign sda_oe = ~sda_r;
	assign loading = (st_r != S_DONE);
	// combinational answer, so it comes in the request cycle itself
	assign tgt_retry = tgt_req & loading;
	assign tgt_ack   = tgt_req & ~loading;
	assign wr_link   = tgt_ack & tgt_wr & (tgt_addr == `SECL_OFS_LINK_ENH);
	assign wr_hc     = tgt_ack & tgt_wr & (tgt_addr == `SECL_OFS_HC_CTRL);
	assign rd_take   = tgt_ack & ~tgt_wr;
	assign ee_commit = tick & (st_r == S_MACK) & (phase_r == 2'd0);

	// enables leave as plain register levels
	assign prio_arb_enable    = prio_r;
	assign phy_accel_support  = accel_r;
	assign phy_program_permit = phyperm_r;

	// reserved bits tie off; bit 6 lives in host control instead
	assign link_enh[31:16] = 16'h0000;
	assign link_enh[15]    = dis_pipe_r;
	assign link_enh[14]    = 1'b0;
	assign link_enh[13:12] = atx_r;
	assign link_enh[11:8]  = 4'h0;
	assign link_enh[7]     = prio_r;
	assign link_enh[6]     = 1'b0;
	assign link_enh[5:2]   = 4'h0;
	assign link_enh[1]     = accel_r;
	assign link_enh[0]     = 1'b0;
	// host control word, only the phy permit bit is kept here
	assign hc_ctrl = {8'h00, phyperm_r, 23'h00_0000};

	// sda pin synchroniser
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
		end else begin
			sda_m_r <= sda_i;
			sda_s_r <= sda_m_r;
		end
	end

	// bit clock divider, quarter periods of scl
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			div_r <= 16'h0000;
		else if (tick)
			div_r <= HALF_CYC[15:0] >> 1;
		else
			div_r <= div_r - 16'h0001;
	end

	// sequential random read from byte 0, one byte acked after another
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= S_START;
			phase_r <= 2'd0;
			bitn_r <= 4'h0;
			sh_r <= 9'h000;
			cmd_r <= 2'd0;
			idx_r <= 5'h00;
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			byte_r <= 8'h00;
		end else if (tick && st_r != S_DONE) begin
			phase_r <= phase_r + 2'd1;
			case (st_r)
			S_START, S_RSTART: begin
				// sda falls while scl is high
				if (phase_r == 2'd0) begin
					// a restart drops scl first so sda may rise safely
					if (st_r == S_START)
						scl_r <= 1'b1;
					else
						scl_r <= 1'b0;
					sda_r <= 1'b1;
				end else if (phase_r == 2'd1)
					scl_r <= 1'b1;
				else if (phase_r == 2'd2)
					sda_r <= 1'b0;   // start: sda falls under high scl
				else begin
					scl_r <= 1'b0;
					st_r <= S_BIT;
					bitn_r <= 4'h0;
					// device address, read flag only after the restart
					if (cmd_r == 2'd2)
						sh_r <= {`SECL_EE_DEV_ADDR, 1'b1, 1'b1};
					else
						sh_r <= {`SECL_EE_DEV_ADDR, 1'b0, 1'b1};
				end
			end
			// one bit per four quarter ticks; sda moves only while scl is low
			S_BIT, S_READ, S_ACK, S_MACK: begin
				if (phase_r == 2'd0) begin
					// release for read data and slave ack; nack only the last byte
					if (st_r == S_READ || st_r == S_ACK)
						sda_r <= 1'b1;
					else if (st_r == S_MACK)
						sda_r <= (idx_r == `SECL_EE_LAST);
					else
						sda_r <= sh_r[8];
				end else if (phase_r == 2'd1)
					scl_r <= 1'b1;
				else if (phase_r == 2'd2) begin
					if (st_r == S_READ)
						byte_r <= {byte_r[6:0], sda_s_r};
				end else begin
					scl_r <= 1'b0;
					bitn_r <= bitn_r + 4'h1;
					sh_r <= {sh_r[7:0], 1'b0};
					if (st_r == S_BIT && bitn_r == 4'h7)
						st_r <= S_ACK;
					else if (st_r == S_READ && bitn_r == 4'h7)
						st_r <= S_MACK;
					else if (st_r == S_ACK) begin
						// no ack stays simple: carry on, bytes read as ones
						bitn_r <= 4'h0;
						if (cmd_r == 2'd0) begin
							cmd_r <= 2'd1;
							st_r <= S_BIT;
							sh_r <= 9'h000;
						end else if (cmd_r == 2'd1) begin
							cmd_r <= 2'd2;
							st_r <= S_RSTART;
						end else
							st_r <= S_READ;
					end else if (st_r == S_MACK) begin
						bitn_r <= 4'h0;
						idx_r <= idx_r + 5'h01;
						if (idx_r == `SECL_EE_LAST)
							st_r <= S_STOP;
						else
							st_r <= S_READ;
					end
				end
			end
			S_STOP: begin
				// sda is pulled low first, with scl still low
				if (phase_r == 2'd0)
					sda_r <= 1'b0;
				else if (phase_r == 2'd1)
					scl_r <= 1'b1;
				else if (phase_r == 2'd3) begin
					// stop: sda rises under high scl, retries end here
					sda_r <= 1'b1;
					st_r <= S_DONE;
				end
			end
			default: st_r <= S_DONE;
			endcase
		end
	end

	// loaded register update, byte committed on master ack phase
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			latgnt_r <= 16'h0000;
			vend_r <= 16'h0000;
			subsys_r <= 16'h0000;
			guid_hi_r <= 32'h0000_0000;
			guid_lo_r <= 32'h0000_0000;
			prio_r <= 1'b0;
			accel_r <= 1'b0;
			phyperm_r <= 1'b0;
			dis_pipe_r <= 1'b0;
			atx_r <= 2'b01;
		end else if (ee_commit) begin
			// byte offset picks the field; unlisted offsets are skipped
			case (idx_r)
			5'h00: latgnt_r <= {byte_r, byte_r};
			// ids arrive low byte first
			5'h01: vend_r[7:0] <= byte_r;
			5'h02: vend_r[15:8] <= byte_r;
			5'h03: subsys_r[7:0] <= byte_r;
			5'h04: subsys_r[15:8] <= byte_r;
			5'h05: begin
				prio_r <= byte_r[`SECL_BIT_PRIO];
				accel_r <= byte_r[`SECL_BIT_ACCEL];
				phyperm_r <= byte_r[`SECL_BIT_PHYPERM];
			end
			5'h07: guid_hi_r[7:0] <= byte_r;
			5'h08: guid_hi_r[15:8] <= byte_r;
			5'h09: guid_hi_r[23:16] <= byte_r;
			5'h0a: guid_hi_r[31:24] <= byte_r;
			5'h0b: guid_lo_r[7:0] <= byte_r;
			5'h0c: guid_lo_r[15:8] <= byte_r;
			5'h0d: guid_lo_r[23:16] <= byte_r;
			5'h0e: guid_lo_r[31:24] <= byte_r;
			5'h10: begin
				dis_pipe_r <= byte_r[7];
				atx_r <= byte_r[5:4];
			end
			default: ;
			endcase
		end else if (wr_link) begin
			// host writes only land after the load, so the two never collide
			prio_r <= tgt_wdata[`SECL_BIT_PRIO];
			accel_r <= tgt_wdata[`SECL_BIT_ACCEL];
			dis_pipe_r <= tgt_wdata[15];
			atx_r <= tgt_wdata[13:12];
		end else if (wr_hc) begin
			phyperm_r <= tgt_wdata[`SECL_BIT_HC_PHYPERM];
		end
	end

	// read data, registered; unmapped reads zero
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			tgt_rdata <= 32'h0000_0000;
		else if (rd_take) begin
			if (tgt_addr == `SECL_OFS_LATGNT)
				tgt_rdata <= {16'h0000, latgnt_r};
			else if (tgt_addr == `SECL_OFS_SUBSYS)
				tgt_rdata <= {subsys_r, vend_r};
			else if (tgt_addr == `SECL_OFS_GUID_HI)
				tgt_rdata <= guid_hi_r;
			else if (tgt_addr == `SECL_OFS_GUID_LO)
				tgt_rdata <= guid_lo_r;
			else if (tgt_addr == `SECL_OFS_LINK_ENH)
				tgt_rdata <= link_enh;
			else if (tgt_addr == `SECL_OFS_HC_CTRL)
				tgt_rdata <= hc_ctrl;
			else
				tgt_rdata <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// ---- pkg/secl_defs.vh ----
// How it works
// - fetch init bytes from serial EEPROM over two-wire bus as initiator.
// - after reset, start read automatically and store bytes into loadable registers.
// - while loading, every PCI target access ends with retry.
// - byte 00h fills latency/grant register at 3Eh bits 15-0.
// - GUID high at 24h, GUID low at 28h, vendor and subsystem ids loaded.
// - priority request enable bit 7 lets link answer priority arbitration.
// - acceleration enable bit 1 tells physical layer acceleration is supported.
// - loaded bit 6 goes to phy_program_permit, control bit 23 at 50h.
// - link enhancement bits 5 to 2 read as zero.
// - link enhancement bit 0 reads as zero.
`ifndef SECL_DEFS_VH
`define SECL_DEFS_VH
`define SECL_OFS_LATGNT     8'h3e
`define SECL_OFS_SUBSYS     8'h2c
`define SECL_OFS_GUID_HI    8'h24
`define SECL_OFS_GUID_LO    8'h28
`define SECL_OFS_LINK_ENH   8'hf4
`define SECL_OFS_HC_CTRL    8'h50
`define SECL_EE_LAST        5'h16
`define SECL_EE_DEV_ADDR    7'h50
`define SECL_BIT_PRIO       7
`define SECL_BIT_PHYPERM    6
`define SECL_BIT_ACCEL      1
`define SECL_BIT_HC_PHYPERM 23
`define SECL_SCL_HALF_NS    5000
`define SECL_CLK_NS         8
`define SECL_LINK_RST       32'h0000_0000
`endif

// ---- verification/secl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "secl_defs.vh"
module secl_chk (
	input wire logic        clk_sys,
	input wire logic        arst_n,
	input wire logic        tgt_req,
	input wire logic        tgt_wr,
	input wire logic [7:0]  tgt_addr,
	input wire logic [31:0] tgt_wdata,
	input wire logic        tgt_retry,
	input wire logic        tgt_ack,
	input wire logic [31:0] tgt_rdata,
	input wire logic        loading,
	input wire logic        prio_arb_enable,
	input wire logic        phy_accel_support,
	input wire logic        phy_program_permit
);
	logic rd_lk;
	logic rd_hc;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// decoded reads; read data lands one cycle later
	assign rd_lk = tgt_ack && !tgt_wr && tgt_addr == `SECL_OFS_LINK_ENH;
	assign rd_hc = tgt_ack && !tgt_wr && tgt_addr == `SECL_OFS_HC_CTRL;
	a_retry_load: assert property (tgt_req && loading |-> tgt_retry && !tgt_ack) else $error("no retry");
	a_ack_done: assert property (tgt_req && !loading |-> tgt_ack && !tgt_retry) else $error("no ack");
	a_load_first: assert property ($rose(arst_n) |-> loading) else $error("no load");
	a_done_stays: assert property ($fell(loading) |=> !loading [*8]) else $error("reload");
	a_prio_read: assert property (rd_lk |=> tgt_rdata[7] == prio_arb_enable) else $error("prio");
	a_accel_read: assert property (rd_lk |=> tgt_rdata[1] == phy_accel_support) else $error("accel");
	a_rsvd_zero: assert property (rd_lk |=> tgt_rdata[6:2] == 5'h0 && !tgt_rdata[0]) else $error("rsvd");
	a_perm_read: assert property (rd_hc |=> tgt_rdata[23] == phy_program_permit) else $error("perm");
	a_wr_prio: assert property (tgt_ack && tgt_wr && tgt_addr == `SECL_OFS_LINK_ENH
		|=> prio_arb_enable == $past(tgt_wdata[7])) else $error("wr prio");
endmodule
bind secl_loader secl_chk u_chk (.*);
`default_nettype wire

// ---- verification/secl_ee.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "secl_defs.vh"
module secl_ee (
	input wire logic scl,
	input wire logic sda,
	output logic     pull
);
	logic [7:0] mem [0:31];
	logic [7:0] sh;
	logic [7:0] ob;
	logic [4:0] a;
	int         bc;
	int         st;
	// fully programmed image, bit 2 of byte 05h kept low
	initial begin
		pull = 1'b0;
		st = 3;
		for (int i = 0; i < 32; i++) mem[i] = 8'h40 + 8'(i);
		mem[5] = 8'hfb;
		mem[16] = 8'hb0;
	end
	// start and stop are sda edges while scl is high
	always @(negedge sda) if (scl) begin bc = -1; st = 0; end
	always @(posedge sda) if (scl) begin st = 3; pull = 1'b0; end
	// master nack on a read ends our driving
	always @(posedge scl) begin
		if (st < 2 && bc < 8) sh = {sh[6:0], sda};
		if (st == 2 && bc == 8 && sda) st = 3;
	end
	// change only while scl is low, released line floats high
	always @(negedge scl) if (st < 3) begin
		bc = bc + 1;
		pull = 1'b0;
		if (bc == 8 && st < 2) pull = sh[7:1] == `SECL_EE_DEV_ADDR || st == 1;
		if (bc == 9) begin
			bc = 0;
			if (st == 1) a = sh[4:0];
			else if (st == 0 && !sh[0]) st = 1;
			else begin st = 2; ob = mem[a]; a = a + 1; end
		end
		if (st == 2 && bc < 8) pull = !ob[7 - bc];
	end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic        tgt_req = 1'b0;
	logic        tgt_wr = 1'b0;
	logic [7:0]  tgt_addr = 8'h00;
	logic [31:0] tgt_wdata = 32'h0000_0000;
	logic [31:0] rd;
	logic        ok;
	wire         scl_o, scl_oe, sda_o, sda_oe, tgt_retry, tgt_ack, loading, pull;
	wire         prio_arb_enable, phy_accel_support, phy_program_permit;
	wire  [31:0] tgt_rdata;
	wire         sda_i = !(sda_oe || pull);
	int          bad_count = 0;
	int          checked = 0;
	int          cyc = 0;
	logic [7:0]  ra [4] = '{8'h3e, 8'h2c, 8'h24, 8'h28};
	logic [31:0] ex [4] = '{32'h0000_4040, 32'h4443_4241, 32'h4a49_4847, 32'h4e4d_4c4b};
	secl_loader #(.HALF_CYC(8)) uut (.*);
	secl_ee u_ee (.scl(!scl_oe), .sda(sda_i), .pull(pull));
	initial forever #4 clk_sys = !clk_sys;
	// one access; the answer is settled well before the taking edge
	task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		@(negedge clk_sys);
		tgt_req = 1'b1;
		tgt_wr = w;
		tgt_addr = ad;
		tgt_wdata = wd;
		#1 ok = tgt_ack;
		@(negedge clk_sys);
		rd = tgt_rdata;
		tgt_req = 1'b0;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// hang guard, the load itself needs about 4740 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin bad_count++; summarize; end
	end
	initial begin
		repeat (3) @(negedge clk_sys);
		arst_n = 1'b1;
		acc(1'b1, 8'hf4, 32'h0000_0000); cmp(32'(ok), 0);
		acc(1'b0, 8'hf4, 32'h0000_0000); cmp(32'(ok), 0);
		for (int i = 0; i < 20000 && loading; i++) @(negedge clk_sys);
		cmp(32'(loading), 0);
		$display("load done");
		for (int i = 0; i < 4; i++) begin
			acc(1'b0, ra[i], 32'h0000_0000); cmp(rd, ex[i]);
		end
		acc(1'b0, 8'hf4, 32'h0000_0000); cmp(rd, 32'h0000_b082);
		acc(1'b0, 8'h50, 32'h0000_0000); cmp({rd[23], phy_program_permit}, 2'b11);
		cmp({prio_arb_enable, phy_accel_support}, 2'b11);
		$display("loaded values done");
		acc(1'b1, 8'hf4, 32'h0000_0000); cmp(32'(ok), 1);
		acc(1'b0, 8'hf4, 32'h0000_0000); cmp(rd, 0);
		cmp({prio_arb_enable, phy_accel_support}, 2'b00);
		acc(1'b1, 8'hf4, 32'hffff_ffff);
		acc(1'b0, 8'hf4, 32'h0000_0000); cmp(rd, 32'h0000_b082);
		cmp({prio_arb_enable, phy_accel_support}, 2'b11);
		$display("writes done");
		summarize;
	end
endmodule
`default_nettype wire
